// ---- hw/rdp_pkg.sv ----
// shared constants for the channel pwm, diagnosis and status registers
package rdp_pkg;
    localparam int unsigned CHANNELS = 8;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;

    // register addresses
    localparam logic [7:0] ADDR_GENERAL_PWM_GENERATOR_SELECT = 8'h0a;
    localparam logic [7:0] ADDR_GENERAL_PWM_DUTY = 8'h0b;
    localparam logic [7:0] ADDR_LED_PWM_DUTY = 8'h0c;
    localparam logic [7:0] ADDR_OFF_DIAG_ENABLE = 8'h0d;
    localparam logic [7:0] ADDR_ON_OPENLOAD_DIAG_ENABLE = 8'h0e;
    localparam logic [7:0] ADDR_OVERLOAD_ERROR_CLEAR = 8'h0f;
    localparam logic [7:0] ADDR_PIN_ECHO_ERROR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_SUPPLY_MODE_STATUS = 8'h11;
    localparam logic [7:0] ADDR_OVERLOAD_RESULT = 8'h12;

    // reset values
    localparam logic [7:0] CTRL_RESET_VAL = 8'h00;
    localparam logic [7:0] OVERLOAD_RESET_VAL = 8'h00;
    localparam logic [2:0] SUPPLY_FLAGS_RESET_VAL = 3'h4;

    // pin echo and error status field positions
    localparam int unsigned STA0_DISABLE_BIT = 6;
    localparam int unsigned STA0_IDLE_BIT = 4;
    localparam int unsigned STA0_IN1_BIT = 3;
    localparam int unsigned STA0_IN0_BIT = 2;
    localparam int unsigned STA0_ON_ERR_BIT = 1;
    localparam int unsigned STA0_OFF_ERR_BIT = 0;

    // supply and mode status field positions
    localparam int unsigned STA1_POWER_ON_BIT = 4;
    localparam int unsigned STA1_IO_LOW_BIT = 3;
    localparam int unsigned STA1_BATT_LOW_BIT = 2;
    localparam int unsigned STA1_MODE_LSB = 0;

    // operating mode codes
    localparam logic [1:0] MODE_SLEEP = 2'h0;
    localparam logic [1:0] MODE_LIMP_HOME = 2'h1;
    localparam logic [1:0] MODE_IDLE = 2'h2;
    localparam logic [1:0] MODE_ACTIVE = 2'h3;

    // pwm timing: slowest frequency in decihertz, 255 steps per period
    localparam longint unsigned CLK_HZ = 200_000_000;
    localparam longint unsigned PWM_BASE_FREQ_DHZ = 1225;
    localparam logic [7:0] PWM_DUTY_OFF = 8'h00;
    localparam logic [7:0] PWM_DUTY_FULL = 8'hff;
    localparam logic [7:0] PWM_STEPS = 8'hff;
    localparam int unsigned PWM_STEP_CYCLES =
        32'((CLK_HZ * 10) / (PWM_BASE_FREQ_DHZ * 255));
endpackage : rdp_pkg

// ---- hw/rdp_gen_if.sv ----
// bundle between the register bank and one pwm generator
`timescale 1ns/1ps
interface rdp_gen_if;
    logic [7:0] duty;
    logic [1:0] divider;
    logic pwm_out;
    modport ctl (output duty, output divider, input pwm_out);
    modport gen (input duty, input divider, output pwm_out);
endinterface : rdp_gen_if

// ---- hw/rdp_sticky.sv ----
// bank of sticky flags, set wins over clear
`timescale 1ns/1ps
module rdp_sticky #(
    parameter int unsigned W = 8,
    parameter logic [W-1:0] RESET_VAL = '0
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic [W-1:0] set,
    input wire logic [W-1:0] clr,
    output logic [W-1:0] q
);
    logic [W-1:0] flag_q;
    logic [W-1:0] flag_d;

    // an event in the clearing cycle survives
    always_comb begin
        flag_d = set | (flag_q & ~clr);
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            flag_q <= RESET_VAL;
        end else begin
            flag_q <= flag_d;
        end
    end

    assign q = flag_q;

    property p_set_wins;
        @(posedge core_clk) disable iff (srst)
        (set != '0) |=> ((flag_q & $past(set)) == $past(set));
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("sticky flag lost its set event");
endmodule : rdp_sticky

// ---- hw/rdp_general_pwm_generator.sv ----
// 8-bit duty pwm generator with 2-bit frequency divider
`timescale 1ns/1ps
module rdp_general_pwm_generator
    import rdp_pkg::*;
#(
    parameter int unsigned STEP_CYCLES = PWM_STEP_CYCLES
) (
    input wire logic core_clk,
    input wire logic ctl_rst,
    rdp_gen_if.gen g
);
    logic [15:0] pre_q;
    logic [15:0] pre_d;
    logic [7:0] step_q;
    logic [7:0] step_d;
    logic out_q;
    logic out_d;
    logic [15:0] limit;

    // each divider step doubles the frequency (see R19)
    assign limit = 16'(STEP_CYCLES >> g.divider);

    // prescaler and 255-step period counter
    always_comb begin
        pre_d = pre_q + 16'h0001;
        step_d = step_q;
        if (pre_q + 16'h0001 >= limit) begin
            pre_d = 16'h0000;
            step_d = (step_q == PWM_STEPS - 8'h01) ? 8'h00 : step_q + 8'h01;
        end
        // zero keeps output off, full scale holds it on (see R3)
        out_d = (g.duty == PWM_DUTY_FULL) || (step_q < g.duty);
    end

    always_ff @(posedge core_clk) begin
        if (ctl_rst) begin
            pre_q <= 16'h0000;
            step_q <= 8'h00;
            out_q <= 1'b0;
        end else begin
            pre_q <= pre_d;
            step_q <= step_d;
            out_q <= out_d;
        end
    end

    assign g.pwm_out = out_q;

    property p_zero_duty_off;
        @(posedge core_clk) disable iff (ctl_rst)
        (g.duty == PWM_DUTY_OFF) [*2] |-> !out_q;
    endproperty
    a_zero_duty_off: assert property (p_zero_duty_off) // see R5
        else $error("pwm output on with zero duty");

    property p_full_duty_on;
        @(posedge core_clk) disable iff (ctl_rst)
        (g.duty == PWM_DUTY_FULL) [*2] |-> out_q;
    endproperty
    a_full_duty_on: assert property (p_full_duty_on) // see R3
        else $error("pwm output off with full duty");
endmodule : rdp_general_pwm_generator

// ---- hw/rdp_regs.sv ----
// channel pwm select, duty, diagnosis enable and status register bank
`timescale 1ns/1ps
// Summary of operation
// (R1) bit n belongs to channel n
// (R2) select bit picks general or led generator
// (R3) general duty: zero off, full on
// (R4) led duty encoded like general duty
// (R5) zero duty turns driven channels off
// (R6) off-state diagnosis enable per channel
// (R7) on-state open-load diagnosis enable per channel
// (R8) write one clears channel overload error
// (R9) four reset sources restore control registers
// (R10) bit 6 echoes disable pin when used
// (R11) bits 4,3,2 echo idle and inputs
// (R12) bit 1 latches any overload error
// (R13) bit 0 latches any off-diagnosis failure
// (R14) power-on flag reads one after reset
// (R15) bit 3 latches io supply undervoltage
// (R16) bit 2 latches battery undervoltage
// (R17) bits 1:0 report operating mode
// (R18) mapping bit gates generator onto channel
// (R19) divider field sets generator frequency
// (R20) result register holds latched overload bits
// (R21) clear register reads zero, self-clears
// (R22) reserved status bits read zero
module rdp_regs
    import rdp_pkg::*;
#(
    parameter int unsigned STEP_CYCLES = PWM_STEP_CYCLES
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic external_reset_pin_n,
    input wire logic soft_reset,
    input wire logic digital_supply_low,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic [1:0] general_pwm_divider,
    input wire logic [1:0] led_pwm_divider,
    input wire logic [7:0] pwm_map,
    input wire logic [7:0] overload_detect,
    input wire logic [7:0] off_diag_fail,
    input wire logic disable_pin,
    input wire logic disable_pin_used,
    input wire logic idle_pin,
    input wire logic parallel_in0,
    input wire logic parallel_in1,
    input wire logic io_supply_low,
    input wire logic battery_low,
    input wire logic [1:0] op_mode,
    output logic [7:0] pwm_channel_drive,
    output logic general_pwm_out,
    output logic led_pwm_out,
    output logic [7:0] off_diag_active,
    output logic [7:0] on_openload_diag_active,
    output logic [7:0] overload_latched
);
    logic ctl_rst;
    logic [7:0] sel_q;
    logic [7:0] sel_d;
    logic [7:0] gen_duty_q;
    logic [7:0] gen_duty_d;
    logic [7:0] led_duty_q;
    logic [7:0] led_duty_d;
    logic [7:0] off_en_q;
    logic [7:0] off_en_d;
    logic [7:0] opl_en_q;
    logic [7:0] opl_en_d;
    logic [7:0] ovl_clear;
    logic [7:0] echo_q;
    logic [7:0] echo_d;
    logic [1:0] err_flags;
    logic [2:0] supply_flags;
    logic [2:0] supply_set;
    logic [2:0] supply_clr;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;

    // write strobe for one address
    function automatic logic wr_hit(input logic [7:0] a);
        wr_hit = reg_wr_en && (reg_addr == a);
    endfunction : wr_hit

    // any of the four reset sources (see R9)
    assign ctl_rst = srst | ~external_reset_pin_n | soft_reset |
                     digital_supply_low;

    // control register next values, bit n is channel n except in the two duty registers (see R1)
    always_comb begin
        sel_d = sel_q;
        gen_duty_d = gen_duty_q;
        led_duty_d = led_duty_q;
        off_en_d = off_en_q;
        opl_en_d = opl_en_q;
        if (wr_hit(ADDR_GENERAL_PWM_GENERATOR_SELECT)) begin
            sel_d = reg_wdata; // see R2
        end
        if (wr_hit(ADDR_GENERAL_PWM_DUTY)) begin
            gen_duty_d = reg_wdata; // see R3
        end
        if (wr_hit(ADDR_LED_PWM_DUTY)) begin
            led_duty_d = reg_wdata; // see R4
        end
        if (wr_hit(ADDR_OFF_DIAG_ENABLE)) begin
            off_en_d = reg_wdata; // see R6
        end
        if (wr_hit(ADDR_ON_OPENLOAD_DIAG_ENABLE)) begin
            opl_en_d = reg_wdata; // see R7
        end
    end

    always_ff @(posedge core_clk) begin
        if (ctl_rst) begin
            sel_q <= CTRL_RESET_VAL; // see R9
            gen_duty_q <= CTRL_RESET_VAL;
            led_duty_q <= CTRL_RESET_VAL;
            off_en_q <= CTRL_RESET_VAL;
            opl_en_q <= CTRL_RESET_VAL;
        end else begin
            sel_q <= sel_d;
            gen_duty_q <= gen_duty_d;
            led_duty_q <= led_duty_d;
            off_en_q <= off_en_d;
            opl_en_q <= opl_en_d;
        end
    end

    // write-only clear acts for one cycle, stores nothing (see R21)
    always_comb begin
        ovl_clear = wr_hit(ADDR_OVERLOAD_ERROR_CLEAR) ? reg_wdata : 8'h00;
    end

    // per-channel overload result, cleared by writing ones (see R8, R20)
    rdp_sticky #(.W(8), .RESET_VAL(OVERLOAD_RESET_VAL)) u_ovl (
        .core_clk (core_clk),
        .srst (srst),
        .set (overload_detect),
        .clr (ovl_clear),
        .q (overload_latched)
    );

    // summary error flags, only power-on reset clears (see R12, R13)
    rdp_sticky #(.W(2), .RESET_VAL(2'h0)) u_err (
        .core_clk (core_clk),
        .srst (srst),
        .set ({|overload_detect, |off_diag_fail}),
        .clr (2'h0),
        .q (err_flags)
    );

    // power-on and supply flags, cleared by reading their register
    assign supply_set = {1'b0, io_supply_low, battery_low};
    assign supply_clr = (reg_rd_en &&
                         reg_addr == ADDR_SUPPLY_MODE_STATUS) ? 3'h7 : 3'h0;

    rdp_sticky #(.W(3), .RESET_VAL(SUPPLY_FLAGS_RESET_VAL)) u_sup (
        .core_clk (core_clk),
        .srst (srst), // see R14
        .set (supply_set), // see R15
        .clr (supply_clr), // see R16
        .q (supply_flags)
    );

    // pin echoes, reserved bits held at zero (see R22)
    always_comb begin
        echo_d = 8'h00;
        echo_d[STA0_DISABLE_BIT] = disable_pin & disable_pin_used; // see R10
        echo_d[STA0_IDLE_BIT] = idle_pin; // see R11
        echo_d[STA0_IN1_BIT] = parallel_in1;
        echo_d[STA0_IN0_BIT] = parallel_in0;
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            echo_q <= 8'h00;
        end else begin
            echo_q <= echo_d;
        end
    end

    // read mux, registered one cycle after the strobe
    always_comb begin
        rdata_d = rdata_q;
        if (reg_rd_en) begin
            unique case (reg_addr)
                ADDR_GENERAL_PWM_GENERATOR_SELECT: rdata_d = sel_q;
                ADDR_GENERAL_PWM_DUTY: rdata_d = gen_duty_q;
                ADDR_LED_PWM_DUTY: rdata_d = led_duty_q;
                ADDR_OFF_DIAG_ENABLE: rdata_d = off_en_q;
                ADDR_ON_OPENLOAD_DIAG_ENABLE: rdata_d = opl_en_q;
                ADDR_OVERLOAD_ERROR_CLEAR: rdata_d = 8'h00; // see R21
                ADDR_PIN_ECHO_ERROR_STATUS: begin
                    rdata_d = echo_q;
                    rdata_d[STA0_ON_ERR_BIT] = err_flags[1]; // see R12
                    rdata_d[STA0_OFF_ERR_BIT] = err_flags[0]; // see R13
                end
                ADDR_SUPPLY_MODE_STATUS: begin
                    rdata_d = 8'h00; // see R22
                    rdata_d[STA1_POWER_ON_BIT] = supply_flags[2];
                    rdata_d[STA1_IO_LOW_BIT] = supply_flags[1];
                    rdata_d[STA1_BATT_LOW_BIT] = supply_flags[0];
                    rdata_d[STA1_MODE_LSB +: 2] = op_mode; // see R17
                end
                ADDR_OVERLOAD_RESULT: rdata_d = overload_latched; // see R20
                default: rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;

    // the two internal generators
    rdp_gen_if gen_bus ();
    rdp_gen_if led_bus ();

    assign gen_bus.duty = gen_duty_q;
    assign gen_bus.divider = general_pwm_divider;
    assign led_bus.duty = led_duty_q;
    assign led_bus.divider = led_pwm_divider;

    rdp_general_pwm_generator #(.STEP_CYCLES(STEP_CYCLES)) u_gen_pwm (
        .core_clk (core_clk),
        .ctl_rst (ctl_rst),
        .g (gen_bus.gen)
    );

    rdp_general_pwm_generator #(.STEP_CYCLES(STEP_CYCLES)) u_led_pwm (
        .core_clk (core_clk),
        .ctl_rst (ctl_rst),
        .g (led_bus.gen)
    );

    assign general_pwm_out = gen_bus.pwm_out;
    assign led_pwm_out = led_bus.pwm_out;

    // route selected generator onto mapped channels (see R2, R18)
    always_comb begin
        for (int n = 0; n < 8; n++) begin
            pwm_channel_drive[n] = pwm_map[n] &
                (sel_q[n] ? led_bus.pwm_out : gen_bus.pwm_out);
        end
    end

    assign off_diag_active = off_en_q; // see R6
    assign on_openload_diag_active = opl_en_q; // see R7

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    property p_ctl_reset;
        !external_reset_pin_n |=> (sel_q == 8'h00 && gen_duty_q == 8'h00 &&
                                   off_en_q == 8'h00 && opl_en_q == 8'h00);
    endproperty
    a_ctl_reset: assert property (p_ctl_reset) // see R9
        else $error("control registers kept after external reset");

    property p_sel_write;
        (reg_wr_en && reg_addr == ADDR_GENERAL_PWM_GENERATOR_SELECT && !ctl_rst) |=>
            sel_q == $past(reg_wdata);
    endproperty
    a_sel_write: assert property (p_sel_write) // see R2
        else $error("select register did not take write");

    property p_clear_zero;
        (reg_rd_en && reg_addr == ADDR_OVERLOAD_ERROR_CLEAR) |=>
            reg_rdata == 8'h00;
    endproperty
    a_clear_zero: assert property (p_clear_zero) // see R21
        else $error("clear register read not zero");

    property p_ovl_clear;
        (reg_wr_en && reg_addr == ADDR_OVERLOAD_ERROR_CLEAR &&
         reg_wdata[0] && !overload_detect[0]) |=> !overload_latched[0];
    endproperty
    a_ovl_clear: assert property (p_ovl_clear) // see R8
        else $error("overload error not cleared by write of one");

    property p_ovl_keep;
        (reg_wr_en && reg_addr == ADDR_OVERLOAD_ERROR_CLEAR &&
         !reg_wdata[7] && overload_latched[7]) |=> overload_latched[7];
    endproperty
    a_ovl_keep: assert property (p_ovl_keep) // see R1
        else $error("overload error cleared by write of zero");

    property p_on_err;
        (|overload_detect) ##1 (reg_rd_en &&
         reg_addr == ADDR_PIN_ECHO_ERROR_STATUS) |=>
            reg_rdata[STA0_ON_ERR_BIT];
    endproperty
    a_on_err: assert property (p_on_err) // see R12
        else $error("overload summary flag not set");

    property p_off_err_hold;
        (err_flags[0] || (|off_diag_fail)) |=> err_flags[0];
    endproperty
    a_off_err_hold: assert property (p_off_err_hold) // see R13
        else $error("off diagnosis summary flag dropped");

    property p_sta1_fields;
        (reg_rd_en && reg_addr == ADDR_SUPPLY_MODE_STATUS) |=>
            (reg_rdata[7:5] == 3'h0 && reg_rdata[1:0] == $past(op_mode));
    endproperty
    a_sta1_fields: assert property (p_sta1_fields) // see R17
        else $error("mode field or reserved bits wrong");

    property p_echo_disable;
        (reg_rd_en && reg_addr == ADDR_PIN_ECHO_ERROR_STATUS) |=>
            (reg_rdata[STA0_DISABLE_BIT] ==
             $past(echo_q[STA0_DISABLE_BIT]) && !reg_rdata[7] &&
             !reg_rdata[5]);
    endproperty
    a_echo_disable: assert property (p_echo_disable) // see R10
        else $error("disable echo or reserved bits wrong");

    property p_unmapped_drive;
        (pwm_map == 8'h00) |-> pwm_channel_drive == 8'h00;
    endproperty
    a_unmapped_drive: assert property (p_unmapped_drive) // see R18
        else $error("unmapped channel driven by generator");
endmodule : rdp_regs

// ---- tb/rdp_host_model.sv ----
// host side of the register strobe port: single byte writes and reads
`timescale 1ns/1ps
module rdp_host_model (
    input wire logic core_clk,
    output logic reg_wr_en,
    output logic reg_rd_en,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata
);
    // idle port values at time zero
    initial begin
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end

    // one write strobe, held until the edge that takes it
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr_en <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr_en <= 1'b0;
        reg_wdata <= ~d;  // no stale data left behind
    endtask : write_reg

    // one read strobe; registered data sampled mid-cycle after the take
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_rd_en <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd_en <= 1'b0;
        reg_addr <= ~a;
        @(negedge core_clk);
        d = reg_rdata;
    endtask : read_reg
endmodule : rdp_host_model

// ---- tb/test_relay_driver_pwm_diag_status_regs.sv ----
// self-checking bench for the pwm, diagnosis and status register bank
`timescale 1ns/1ps
module test_relay_driver_pwm_diag_status_regs;
    import rdp_pkg::*;
    localparam int unsigned STEPS = 8;
    localparam int LIMIT = 60000;
    logic core_clk, srst, external_reset_pin_n, soft_reset;
    logic digital_supply_low, reg_wr_en, reg_rd_en;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, pwm_map;
    logic [1:0] general_pwm_divider, led_pwm_divider, op_mode;
    logic [7:0] overload_detect, off_diag_fail, pwm_channel_drive;
    logic disable_pin, disable_pin_used, idle_pin, parallel_in0;
    logic parallel_in1, io_supply_low, battery_low;
    logic general_pwm_out, led_pwm_out;
    logic [7:0] off_diag_active, on_openload_diag_active, overload_latched;
    int bad_count = 0;
    int tests_run = 0;
    int cycles = 0;

    rdp_regs #(.STEP_CYCLES(STEPS)) uut (.core_clk, .srst,
        .external_reset_pin_n, .soft_reset, .digital_supply_low,
        .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata,
        .general_pwm_divider, .led_pwm_divider, .pwm_map,
        .overload_detect, .off_diag_fail, .disable_pin,
        .disable_pin_used, .idle_pin, .parallel_in0, .parallel_in1,
        .io_supply_low, .battery_low, .op_mode, .pwm_channel_drive,
        .general_pwm_out, .led_pwm_out, .off_diag_active,
        .on_openload_diag_active, .overload_latched);

    rdp_host_model host (.core_clk, .reg_wr_en, .reg_rd_en, .reg_addr,
        .reg_wdata, .reg_rdata);

    // 200 mhz clock
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // hang guard
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            bad_count++;
            $display("BAD t=%0t run did not finish in time", $time);
            wrap_up();
        end
    end

    // expected status bytes and channel drive
    function automatic logic [7:0] sta0_exp(input logic on_e, off_e);
        return {1'b0, disable_pin & disable_pin_used, 1'b0, idle_pin,
            parallel_in1, parallel_in0, on_e, off_e};
    endfunction : sta0_exp
    function automatic logic [7:0] sta1_exp(input logic io, bat,
        input logic [1:0] md);
        return {3'h0, 1'b0, io, bat, md};
    endfunction : sta1_exp
    function automatic logic [7:0] drive_exp(input logic [7:0] map, sel,
        input logic g, l);
        return map & ((~sel & {8{g}}) | (sel & {8{l}}));
    endfunction : drive_exp

    task automatic check(input logic [15:0] seen, input logic [15:0] exp,
        input string what);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t %s seen %h want %h", $time, what, seen, exp);
        end
    endtask : check
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        host.read_reg(a, d);
        check(d, exp, $sformatf("read %h", a));
    endtask : rd_chk
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask : cyc
    task automatic look;
        @(negedge core_clk);
    endtask : look
    task automatic done(input string name);
        $display("test %s ends: %0d checks, %0d bad", name, tests_run,
            bad_count);
    endtask : done
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : wrap_up

    // main sequence
    initial begin
        logic [7:0] v [5];
        logic [7:0] m, sel, map, duty;
        int hi;
        {srst, external_reset_pin_n} = 2'h3;
        {soft_reset, digital_supply_low, disable_pin} = 3'h0;
        {disable_pin_used, idle_pin, parallel_in0, parallel_in1} = 4'h0;
        {io_supply_low, battery_low, op_mode} = 4'h0;
        {general_pwm_divider, led_pwm_divider} = 4'h0;
        {pwm_map, overload_detect, off_diag_fail} = 24'h000000;
        void'($urandom(32'hbdf9d77a));
        cyc(20);
        srst <= 1'b0;
        // reset values, write-only and unmapped places
        for (int a = 10; a <= 16; a++) rd_chk(8'(a), 8'h00);
        rd_chk(ADDR_SUPPLY_MODE_STATUS, 8'h10);
        rd_chk(ADDR_SUPPLY_MODE_STATUS, 8'h00);
        host.write_reg(8'h13, 8'hff);
        rd_chk(8'h13, 8'h00);
        rd_chk(8'hff, 8'h00);
        done("reset values");
        // pin echoes
        for (int i = 0; i < 6; i++) begin
            cyc(1);
            {disable_pin, disable_pin_used, idle_pin, parallel_in1,
                parallel_in0} <= 5'($urandom);
            cyc(2);
            rd_chk(ADDR_PIN_ECHO_ERROR_STATUS, sta0_exp(0, 0));
        end
        done("echoes");
        // overload latch, summary flags and write-one clear
        m = 8'($urandom) | 8'h81;
        cyc(1);
        overload_detect <= m;
        cyc(1);
        overload_detect <= 8'h00;
        cyc(2);
        look();
        check(overload_latched, m, "latched");
        rd_chk(ADDR_OVERLOAD_RESULT, m);
        cyc(1);
        off_diag_fail <= 8'h40;
        cyc(1);
        off_diag_fail <= 8'h00;
        rd_chk(ADDR_PIN_ECHO_ERROR_STATUS, sta0_exp(1, 1));
        host.write_reg(ADDR_OVERLOAD_ERROR_CLEAR, 8'h01);
        cyc(2);
        look();
        check(overload_latched, m & 8'hfe, "clear");
        rd_chk(ADDR_OVERLOAD_ERROR_CLEAR, 8'h00);
        host.write_reg(ADDR_PIN_ECHO_ERROR_STATUS, 8'hff);
        rd_chk(ADDR_PIN_ECHO_ERROR_STATUS, sta0_exp(1, 1));
        done("overload");
        // control registers against the external pin, soft reset and digital supply reset sources
        for (int s = 0; s < 3; s++) begin
            for (int i = 0; i < 5; i++) begin
                v[i] = 8'($urandom) | 8'h01;
                host.write_reg(8'(ADDR_GENERAL_PWM_GENERATOR_SELECT + i), v[i]);
            end
            for (int i = 0; i < 5; i++)
                rd_chk(8'(10 + i), v[i]);
            look();
            check(off_diag_active, v[3], "off diag");
            check(on_openload_diag_active, v[4], "on diag");
            cyc(1);
            case (s)
                0: external_reset_pin_n <= 1'b0;
                1: soft_reset <= 1'b1;
                default: digital_supply_low <= 1'b1;
            endcase
            cyc(1);
            external_reset_pin_n <= 1'b1;
            soft_reset <= 1'b0;
            digital_supply_low <= 1'b0;
            for (int i = 0; i < 5; i++) rd_chk(8'(10 + i), 8'h00);
            look();
            check(off_diag_active, 8'h00, "off diag reset");
            check(on_openload_diag_active, 8'h00, "on diag reset");
            check(overload_latched, m & 8'hfe, "kept");
        end
        done("control resets");
        // supply flags and operating mode
        host.write_reg(ADDR_SUPPLY_MODE_STATUS, 8'hff);
        for (int k = 0; k < 4; k++) begin
            cyc(1);
            op_mode <= 2'(k);
            io_supply_low <= (k == 1);
            battery_low <= (k == 2);
            cyc(1);
            io_supply_low <= 1'b0;
            battery_low <= 1'b0;
            rd_chk(8'h11, sta1_exp(k == 1, k == 2, 2'(k)));
            rd_chk(8'h11, sta1_exp(0, 0, 2'(k)));
        end
        done("supply and mode");
        // generator routing onto channels with off and full duty
        for (int i = 0; i < 4; i++) begin
            sel = 8'($urandom);
            map = i ? 8'($urandom) : 8'hff;
            host.write_reg(ADDR_GENERAL_PWM_GENERATOR_SELECT, sel);
            host.write_reg(ADDR_GENERAL_PWM_DUTY, i[0] ? 8'h00 : 8'hff);
            host.write_reg(ADDR_LED_PWM_DUTY, i[0] ? 8'hff : 8'h00);
            cyc(1);
            pwm_map <= map;
            cyc(3);
            look();
            check(pwm_channel_drive, drive_exp(map, sel, !i[0], i[0]),
                "drive");
        end
        done("routing");
        // high time over one period for every divider
        for (int g = 0; g < 2; g++) begin
            for (int dv = 0; dv < 4; dv++) begin
                duty = 8'($urandom_range(254, 1));
                host.write_reg(g ? ADDR_LED_PWM_DUTY : ADDR_GENERAL_PWM_DUTY,
                    duty);
                cyc(1);
                general_pwm_divider <= 2'(dv);
                led_pwm_divider <= 2'(dv);
                cyc(510 * (STEPS >> dv));
                hi = 0;
                repeat (255 * (STEPS >> dv)) begin
                    look();
                    hi += g ? led_pwm_out : general_pwm_out;
                end
                check(16'(hi), 16'(duty) * 16'(STEPS >> dv),
                    "high");
            end
        end
        done("duty");
        // power-on reset in mid-run
        cyc(1);
        srst <= 1'b1;
        cyc(2);
        srst <= 1'b0;
        rd_chk(ADDR_SUPPLY_MODE_STATUS, 8'h13);
        rd_chk(ADDR_PIN_ECHO_ERROR_STATUS, sta0_exp(0, 0));
        look();
        check(overload_latched, 8'h00, "por clear");
        done("power-on reset");
        wrap_up();
    end
endmodule : test_relay_driver_pwm_diag_status_regs
